// >>> verilog/lgb_pkg.sv
// Constants shared by the luma gamma, brightness and clock-out block
package lgb_pkg;
  // Register offsets on the serial host register port
  localparam logic [5:0] ADDR_GAMMA_BASE = 6'h26;
  localparam logic [5:0] ADDR_GAMMA_LAST = 6'h33;
  localparam logic [5:0] ADDR_AVG_LUMA   = 6'h34;
  localparam logic [5:0] ADDR_OCR        = 6'h35;
  localparam int         GAMMA_REGS      = 14;
  localparam int         CURVE_POINTS    = 7;
  // Output clock register layout and reset value, and gamma point reset step
  localparam int         OCR_AUX_CLOCK_OUTPUT_PIN_BIT  = 1;
  localparam logic [7:0] OCR_RST         = 8'h70;
  localparam logic [7:0] GAMMA_STEP_RST  = 8'h20;
  // Gamma curve geometry
  localparam logic [7:0] LUMA_LO         = 8'h10;
  localparam logic [7:0] LUMA_HI         = 8'hF0;
  localparam logic [7:0] KNOT_FIRST      = 8'h20;
  localparam logic [7:0] KNOT_LAST       = 8'hE0;
  localparam int         EDGE_SHIFT      = 4;
  localparam int         MID_SHIFT       = 5;
  // Brightness accumulator sizes
  localparam int         SUM_W           = 26;
  localparam int         CNT_W           = 18;
  localparam int         DIV_STEP_W      = 5;
  // Pixel buffer
  localparam int         FIFO_DEPTH      = 8;
  localparam int         FIFO_WIDTH      = 9;
  // Clock rates
  localparam int         CLK_HZ          = 50_000_000;
  localparam int         AUX_CLK_HZ      = 54_000_000;
endpackage

// >>> verilog/lgb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lgb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_valid_out && out_ready_in;
  assign out_data_out = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // Flags registered so both handshakes come straight from flops
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      count_q       <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q       <= count_d;
      in_ready_out  <= (count_d != (AW+1)'(DEPTH));
      out_valid_out <= (count_d != '0);
    end
  end
endmodule

// >>> verilog/lgb_luma_proc.sv
// Luma gamma stage, field brightness monitor and aux clock gate control
`timescale 1ns/1ps
// How it works
// [R1] Fourteen writable byte registers hold curve points
// [R2] Gamma touches luma only; chroma passes unchanged
// [R3] Exactly one curve active, picked by select
// [R4] Codes 32..224 step 32 map to points
// [R5] Between points output is linearly interpolated
// [R6] Codes 0,16,240,255 map to themselves, fixed
// [R7] Host computes points as scaled power law
// [R8] Host keeps every point within 16..240
// [R9] Average luma register is read only
// [R10] Only active-area luma samples are averaged
// [R11] Average updates after each vsync falling edge
// [R12] Clock-out bit gates 54 MHz aux clock
// [R13] Gate only when PLL and oversampling on
// [R14] Host writes fixed ones and zeros there
// [R15] Interpolated output rounded, clamped to 16..240
module lgb_luma_proc
  import lgb_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port from the serial host front end
  input  wire logic [5:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Pixel stream in
  input  wire logic       pix_valid_in,
  input  wire logic [7:0] pix_data_in,
  input  wire logic       pix_is_luma_in,
  input  wire logic       pix_active_in,
  output logic            pix_ready_out,
  // Pixel stream out
  output logic            out_valid_out,
  output logic      [7:0] out_data_out,
  output logic            out_is_luma_out,
  input  wire logic       out_ready_in,
  // Video timing pin
  input  wire logic       vsync_n_in,
  // Controls from the mode registers
  input  wire logic       curve_b_sel_in,
  input  wire logic       pll_disable_bit_in,
  input  wire logic       oversample_enable_bit_in,
  // Aux clock pad gate
  output logic            aux_clk_en_out
);
  logic [7:0]            gamma_q [0:GAMMA_REGS-1];
  logic [7:0]            pt [0:CURVE_POINTS-1];
  logic [7:0]            ocr_q;
  logic [7:0]            avg_q;
  logic                  head_valid;
  logic [FIFO_WIDTH-1:0] head;
  logic                  pop;
  logic                  acc_fire;
  logic                  vs_s1_q;
  logic                  vs_s2_q;
  logic                  vs_s3_q;
  logic                  vs_lvl_q;
  logic                  vs_fall;
  logic [SUM_W-1:0]      sum_q;
  logic [CNT_W-1:0]      cnt_q;
  logic [SUM_W-1:0]      div_dvd_q;
  logic [CNT_W-1:0]      div_dsr_q;
  logic [CNT_W-1:0]      div_rem_q;
  logic [CNT_W:0]        rem_sh;
  logic [DIV_STEP_W-1:0] div_step_q;
  logic                  div_busy_q;
  logic                  div_last;
  logic [7:0]            gx;
  logic [7:0]            gy;
  logic [7:0]            y0;
  logic [7:0]            y1;
  logic [7:0]            x0;
  logic [4:0]            off;
  logic [2:0]            idx;
  logic                  wide_seg;
  logic                  bypass;
  logic signed [8:0]     diff;
  logic signed [14:0]    prod;
  logic signed [14:0]    rnd;
  logic signed [9:0]     ysum;
  logic [7:0]            knot_exp;
  logic [7:0]            mid_exp;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Curve point registers and active-curve view
  for (genvar k = 0; k < GAMMA_REGS; k++) begin : g_gamma
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        gamma_q[k] <= 8'((k % CURVE_POINTS + 1) * GAMMA_STEP_RST);
      end else if (reg_wr_in && reg_addr_in == 6'(ADDR_GAMMA_BASE + k)) begin
        gamma_q[k] <= reg_wdata_in; // [R1]
      end
    end
    if (k < CURVE_POINTS) begin : g_pt
      assign pt[k] = curve_b_sel_in ? gamma_q[k + CURVE_POINTS] : gamma_q[k]; // [R3]
    end
  end

  AST_POINT_WRITE: assert property ( // [R1]
    reg_wr_in && reg_addr_in >= ADDR_GAMMA_BASE && reg_addr_in <= ADDR_GAMMA_LAST
    |=> gamma_q[4'($past(reg_addr_in) - ADDR_GAMMA_BASE)] == $past(reg_wdata_in))
    else $error("curve point write not stored");
  // Output clock register; stored whole so reads return what was written
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ocr_q <= OCR_RST;
    end else if (reg_wr_in && reg_addr_in == ADDR_OCR) begin
      ocr_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aux_clk_en_out <= 1'b0;
    end else begin
      aux_clk_en_out <= ocr_q[OCR_AUX_CLOCK_OUTPUT_PIN_BIT] // [R12]
                        && !pll_disable_bit_in && oversample_enable_bit_in; // [R13]
    end
  end

  AST_CLK_GATE: assert property ( // [R13]
    aux_clk_en_out |-> $past(ocr_q[OCR_AUX_CLOCK_OUTPUT_PIN_BIT]) && $past(!pll_disable_bit_in)
                       && $past(oversample_enable_bit_in))
    else $error("aux clock enabled without PLL and oversampling");
  AST_CLK_ON: assert property ( // [R12]
    ocr_q[OCR_AUX_CLOCK_OUTPUT_PIN_BIT] && !pll_disable_bit_in && oversample_enable_bit_in
    |=> aux_clk_en_out)
    else $error("aux clock not enabled when requested");
  // Read port; average register ignores writes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in >= ADDR_GAMMA_BASE && reg_addr_in <= ADDR_GAMMA_LAST) begin
        reg_rdata_out <= gamma_q[4'(reg_addr_in - ADDR_GAMMA_BASE)];
      end else if (reg_addr_in == ADDR_AVG_LUMA) begin
        reg_rdata_out <= avg_q; // [R9]
      end else if (reg_addr_in == ADDR_OCR) begin
        reg_rdata_out <= ocr_q;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // Pixel buffer; its ready is the upstream back-pressure
  lgb_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (pix_valid_in),
    .in_data_in    ({pix_is_luma_in, pix_data_in}),
    .in_ready_out  (pix_ready_out),
    .out_valid_out (head_valid),
    .out_data_out  (head),
    .out_ready_in  (pop)
  );

  assign pop = head_valid && (!out_valid_out || out_ready_in);
  assign gx  = head[7:0];

  // Gamma transfer: piecewise linear over fixed and programmed knots
  always_comb begin
    bypass   = 1'b1;
    wide_seg = 1'b0;
    idx      = 3'h0;
    x0       = 8'h00;
    y0       = 8'h00;
    y1       = 8'h00;
    if (gx >= LUMA_LO && gx < KNOT_FIRST) begin
      bypass = 1'b0;
      x0     = LUMA_LO;
      y0     = LUMA_LO;
      y1     = pt[0];
    end else if (gx >= KNOT_FIRST && gx < KNOT_LAST) begin
      bypass   = 1'b0;
      wide_seg = 1'b1;
      idx      = 3'(gx[7:5] - 3'h1); // [R4]
      x0       = {gx[7:5], 5'h00};
      y0       = pt[idx];
      y1       = pt[3'(idx + 3'h1)];
    end else if (gx >= KNOT_LAST && gx < LUMA_HI) begin
      bypass = 1'b0;
      x0     = KNOT_LAST;
      y0     = pt[CURVE_POINTS-1];
      y1     = LUMA_HI;
    end
    off  = 5'(gx - x0);
    diff = $signed({1'b0, y1}) - $signed({1'b0, y0});
    prod = diff * $signed({1'b0, off}); // [R5]
    // Round half up before the shift so ramps stay symmetric
    if (wide_seg) begin
      rnd = (prod + 15'sd16) >>> MID_SHIFT;
    end else begin
      rnd = (prod + 15'sd8) >>> EDGE_SHIFT;
    end
    ysum = $signed({2'b00, y0}) + $signed(rnd[9:0]);
    if (bypass) begin
      gy = gx; // [R6]
    end else if (ysum < $signed({2'b00, LUMA_LO})) begin
      gy = LUMA_LO; // [R15]
    end else if (ysum > $signed({2'b00, LUMA_HI})) begin
      gy = LUMA_HI; // [R15]
    end else begin
      gy = ysum[7:0];
    end
  end

  // Output stage; chroma bypasses the curve
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_valid_out   <= 1'b0;
      out_data_out    <= 8'h00;
      out_is_luma_out <= 1'b0;
    end else if (pop) begin
      out_valid_out   <= 1'b1;
      out_data_out    <= head[8] ? gy : gx; // [R2]
      out_is_luma_out <= head[8];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end

  assign knot_exp = pt[3'(gx[7:5] - 3'h1)];
  assign mid_exp  = 8'((9'(pt[0]) + 9'(pt[1]) + 9'h001) >> 1);

  AST_CHROMA_PASS: assert property ( // [R2]
    pop && !head[8] |=> out_valid_out && out_data_out == $past(gx))
    else $error("chroma sample altered");
  AST_FIXED_ENDS: assert property ( // [R6]
    pop && head[8] && (gx < LUMA_LO || gx >= LUMA_HI) |=> out_data_out == $past(gx))
    else $error("fixed end of curve not identity");
  AST_KNOT: assert property ( // [R4]
    pop && head[8] && gx[4:0] == 5'h00 && gx >= KNOT_FIRST && gx <= KNOT_LAST
    && knot_exp >= LUMA_LO && knot_exp <= LUMA_HI
    |=> out_data_out == $past(knot_exp))
    else $error("knot output differs from programmed point");
  AST_CURVE_B: assert property ( // [R3]
    pop && head[8] && gx == KNOT_FIRST && curve_b_sel_in
    && gamma_q[CURVE_POINTS] >= LUMA_LO && gamma_q[CURVE_POINTS] <= LUMA_HI
    |=> out_data_out == $past(gamma_q[CURVE_POINTS]))
    else $error("curve B not in effect");
  AST_MIDPOINT: assert property ( // [R5]
    pop && head[8] && gx == 8'h30 && pt[0] >= LUMA_LO && pt[1] <= LUMA_HI
    && pt[0] <= LUMA_HI && pt[1] >= LUMA_LO
    |=> out_data_out == $past(mid_exp))
    else $error("midpoint not interpolated");
  AST_CLAMP: assert property ( // [R15]
    pop && head[8] && gx >= LUMA_LO && gx <= LUMA_HI
    |=> out_data_out >= LUMA_LO && out_data_out <= LUMA_HI)
    else $error("luma left 16..240");

  // Vsync pin: three flops, a change counts once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vs_s1_q  <= 1'b1;
      vs_s2_q  <= 1'b1;
      vs_s3_q  <= 1'b1;
      vs_lvl_q <= 1'b1;
    end else begin
      vs_s1_q <= vsync_n_in;
      vs_s2_q <= vs_s1_q;
      vs_s3_q <= vs_s2_q;
      if (vs_s2_q == vs_s3_q) begin
        vs_lvl_q <= vs_s3_q;
      end
    end
  end

  assign vs_fall  = vs_lvl_q && vs_s2_q == vs_s3_q && !vs_s3_q;
  // Counted at acceptance, so buffered pixels land in the field they arrived in
  assign acc_fire = pix_valid_in && pix_ready_out && pix_is_luma_in && pix_active_in;

  // Field accumulators; a sample on the edge cycle opens the new field
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sum_q <= '0;
      cnt_q <= '0;
    end else if (vs_fall) begin
      sum_q <= acc_fire ? SUM_W'(pix_data_in) : '0;
      cnt_q <= acc_fire ? CNT_W'(1) : '0;
    end else if (acc_fire) begin
      sum_q <= sum_q + SUM_W'(pix_data_in); // [R10]
      cnt_q <= cnt_q + 1'b1; // [R10]
    end
  end
  AST_ACC_ONLY_ACTIVE: assert property ( // [R10]
    !vs_fall && !acc_fire |=> $stable(cnt_q) && $stable(sum_q))
    else $error("accumulated outside active luma");

  // Restoring divider: one quotient bit per cycle after each field edge
  assign rem_sh   = {div_rem_q, div_dvd_q[SUM_W-1]};
  assign div_last = div_step_q == DIV_STEP_W'(SUM_W - 1);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_busy_q <= 1'b0;
      div_step_q <= '0;
      div_dvd_q  <= '0;
      div_dsr_q  <= '0;
      div_rem_q  <= '0;
    end else if (vs_fall) begin
      div_busy_q <= 1'b1; // [R11]
      div_step_q <= '0;
      div_dvd_q  <= sum_q;
      div_dsr_q  <= cnt_q;
      div_rem_q  <= '0;
    end else if (div_busy_q) begin
      div_step_q <= div_step_q + 1'b1;
      div_busy_q <= !div_last;
      if (rem_sh >= {1'b0, div_dsr_q}) begin
        div_rem_q <= CNT_W'(rem_sh - {1'b0, div_dsr_q});
        div_dvd_q <= {div_dvd_q[SUM_W-2:0], 1'b1};
      end else begin
        div_rem_q <= rem_sh[CNT_W-1:0];
        div_dvd_q <= {div_dvd_q[SUM_W-2:0], 1'b0};
      end
    end
  end

  // Field with no active luma reports zero rather than a divide fault
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      avg_q <= 8'h00;
    end else if (div_busy_q && div_last && !vs_fall) begin
      if (div_dsr_q == '0) begin
        avg_q <= 8'h00;
      end else if (|div_dvd_q[SUM_W-2:7]) begin
        avg_q <= 8'hFF;
      end else begin
        avg_q <= {div_dvd_q[6:0], rem_sh >= {1'b0, div_dsr_q}}; // [R11]
      end
    end
  end

  sequence field_edge_s;
    vs_fall;
  endsequence
  // Busy for SUM_W cycles; fields are far longer, so no restart is expected
  sequence divide_s;
    div_busy_q [*8] ##1 div_busy_q [*8] ##1 div_busy_q [*8] ##1 div_busy_q [*2] ##1 !div_busy_q;
  endsequence
  AST_AVG_AFTER_EDGE: assert property ( // [R11]
    field_edge_s |=> divide_s)
    else $error("divider did not run one full update after field edge");
  AST_AVG_DIVIDES: assert property ( // [R11]
    field_edge_s ##1 (!vs_fall) [*8] ##1 (!vs_fall) [*8] ##1 (!vs_fall) [*8]
    |-> $past(div_busy_q, 8))
    else $error("divider not running after field edge");
  AST_AVG_WHEN_DONE: assert property ( // [R11]
    $changed(avg_q) |-> $past(div_busy_q) && $past(div_last) && $past(!vs_fall))
    else $error("average changed outside field update");
  AST_AVG_RO: assert property ( // [R9]
    reg_wr_in && reg_addr_in == ADDR_AVG_LUMA && !div_busy_q |=> $stable(avg_q))
    else $error("write reached average register");
endmodule

// >>> verification/lgb_pix_source.sv
// Upstream pixel source model that holds each sample until it is taken
`timescale 1ns/1ps
module lgb_pix_source (
  // Clock
  input  wire logic       clk_in,
  // Sample handshake
  input  wire logic       ready_in,
  output logic            valid_out,
  output logic      [7:0] data_out,
  output logic            luma_out,
  output logic            active_out,
  // Status to the bench
  output logic            idle_out
);
  logic [9:0] pend_q[$];
  logic       taken;

  initial begin
    valid_out = 1'b0;
    data_out = 8'h00;
    luma_out = 1'b0;
    active_out = 1'b0;
    idle_out = 1'b1;
  end

  task automatic send(input logic [7:0] d, input logic l, input logic a);
    pend_q.push_back({a, l, d});
  endtask

  // Ready is sampled at the rising edge, changes land on the falling edge
  always begin
    @(posedge clk_in);
    taken = valid_out && ready_in;
    @(negedge clk_in);
    // Each signal is written at most once per falling edge
    if ((taken || !valid_out) && pend_q.size() > 0) begin
      {active_out, luma_out, data_out} = pend_q.pop_front();
      valid_out = 1'b1;
    end else if (taken) begin
      valid_out = 1'b0;
      // Released data must not look like the last sample
      data_out = ~data_out;
    end
    idle_out = !valid_out && (pend_q.size() == 0);
  end
endmodule

// >>> verification/lgb_luma_proc_bench.sv
// Self-checking bench for the luma gamma, brightness and clock-out block
`timescale 1ns/1ps
module lgb_luma_proc_bench
  import lgb_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [5:0] reg_addr_in = 6'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       pix_valid_in, pix_is_luma_in, pix_active_in, pix_ready_out, src_idle;
  logic [7:0] pix_data_in, out_data_out;
  logic       out_valid_out, out_is_luma_out, aux_clk_en_out;
  logic       out_ready_in = 1'b1;
  logic       vsync_n_in = 1'b1;
  logic       curve_b_sel_in = 1'b0;
  logic       pll_disable_bit_in = 1'b0;
  logic       oversample_enable_bit_in = 1'b1;
  int         n_errors = 0;
  int         total_checks = 0;
  int         pa[7] = '{76, 120, 150, 174, 195, 214, 231};
  int         pb[7] = '{20, 30, 45, 70, 110, 160, 220};
  int         codes[16] = '{0, 8, 16, 24, 32, 47, 48, 64, 100, 128, 200, 224, 232, 240, 250, 255};
  logic [9:0] field_set[6] = '{10'h340, 10'h380, 10'h3C0, 10'h350, 10'h1FF, 10'h2FF};
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int         sum = 0;
  int         cnt = 0;
  logic [7:0] avg_exp = 8'h00;

  always #10 clk_in = ~clk_in;

  lgb_luma_proc #(.DEPTH(FIFO_DEPTH)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pix_valid_in(pix_valid_in), .pix_data_in(pix_data_in), .pix_is_luma_in(pix_is_luma_in),
    .pix_active_in(pix_active_in), .pix_ready_out(pix_ready_out),
    .out_valid_out(out_valid_out), .out_data_out(out_data_out),
    .out_is_luma_out(out_is_luma_out), .out_ready_in(out_ready_in),
    .vsync_n_in(vsync_n_in), .curve_b_sel_in(curve_b_sel_in),
    .pll_disable_bit_in(pll_disable_bit_in),
    .oversample_enable_bit_in(oversample_enable_bit_in), .aux_clk_en_out(aux_clk_en_out));

  lgb_pix_source src (
    .clk_in(clk_in), .ready_in(pix_ready_out), .valid_out(pix_valid_in),
    .data_out(pix_data_in), .luma_out(pix_is_luma_in), .active_out(pix_active_in),
    .idle_out(src_idle));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    @(negedge clk_in);
    check(n, exp, reg_rdata_out);
  endtask

  // Knots at 16, 32..224 step 32, 240; outer segments are half width
  function automatic logic [7:0] gexp(input int x, input logic b);
    int p[9];
    int i, kx, sh, y;
    p[0] = 16;
    p[8] = 240;
    for (int k = 1; k < 8; k++) p[k] = b ? pb[k-1] : pa[k-1];
    if (x < 16 || x >= 240) return x[7:0];
    i = (x < 32) ? 0 : (x >= 224) ? 7 : x / 32;
    kx = (i == 0) ? 16 : 32 * i;
    sh = (i == 0 || i == 7) ? 4 : 5;
    y = p[i] + (((p[i+1] - p[i]) * (x - kx) + (1 << (sh - 1))) >>> sh);
    y = (y < 16) ? 16 : (y > 240) ? 240 : y;
    return y[7:0];
  endfunction

  task automatic push(input logic [7:0] d, input logic l, input logic a);
    src.send(d, l, a);
    exp_q.push_back({l, l ? gexp(int'(d), curve_b_sel_in) : d});
    if (l && a) begin
      sum += int'(d);
      cnt++;
    end
  endtask

  task automatic drain();
    int t;
    t = 0;
    repeat (3) @(negedge clk_in);
    while ((!src_idle || exp_q.size() != 0) && t < 300) begin
      @(negedge clk_in);
      t++;
    end
    if (t >= 300) begin
      n_errors++;
      $display("FAIL drain expected empty seen busy");
    end
  endtask

  // Field average counts raw input codes of active luma only
  task automatic vfall();
    @(negedge clk_in);
    vsync_n_in = 1'b0;
    avg_exp = (cnt == 0) ? 8'h00 : (sum / cnt > 255) ? 8'hFF : 8'(sum / cnt);
    sum = 0;
    cnt = 0;
    repeat (8) @(negedge clk_in);
    vsync_n_in = 1'b1;
    repeat (40) @(negedge clk_in);
  endtask

  always @(posedge clk_in) begin
    if (rst_n_in && out_valid_out && out_ready_in) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("FAIL out_data_out expected none seen %h", out_data_out);
      end else begin
        e = exp_q.pop_front();
        check("out_data_out", e[7:0], out_data_out);
        check("out_is_luma_out", {7'h00, e[8]}, {7'h00, out_is_luma_out});
      end
    end
  end

  initial begin
    #400_000;
    n_errors++;
    $display("FAIL watchdog expected finish seen timeout");
    complete_run();
  end

  initial begin
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    check("pix_ready_out", 8'h01, {7'h00, pix_ready_out});
    rd_chk("ocr_reset", ADDR_OCR, OCR_RST);
    rd_chk("avg_reset", ADDR_AVG_LUMA, 8'h00);
    for (int i = 0; i < 14; i++)
      rd_chk("gamma_reset", ADDR_GAMMA_BASE + 6'(i), GAMMA_STEP_RST * 8'(i % 7 + 1));
    for (int i = 0; i < 7; i++) begin
      reg_wr(ADDR_GAMMA_BASE + 6'(i), 8'(pa[i]));
      reg_wr(ADDR_GAMMA_BASE + 6'(i + 7), 8'(pb[i]));
    end
    for (int i = 0; i < 14; i++)
      rd_chk("gamma_point", ADDR_GAMMA_BASE + 6'(i), 8'(i < 7 ? pa[i] : pb[i-7]));
    reg_wr(ADDR_AVG_LUMA, 8'h5A);
    rd_chk("avg_readonly", ADDR_AVG_LUMA, 8'h00);
    rd_chk("unmapped", 6'h3F, 8'h00);
    for (int c = 0; c < 2; c++) begin
      curve_b_sel_in = c[0];
      foreach (codes[i]) push(8'(codes[i]), 1'b1, 1'b1);
      push(8'hC8, 1'b0, 1'b1);
      drain();
    end
    // Downstream stall fills the buffer, then everything must come out in order
    out_ready_in = 1'b0;
    for (int i = 0; i < 12; i++) push(8'(16 * i + 4), i[0], 1'b0);
    repeat (20) @(negedge clk_in);
    check("pix_ready_out_full", 8'h00, {7'h00, pix_ready_out});
    out_ready_in = 1'b1;
    drain();
    for (int f = 0; f < 2; f++) begin
      if (f == 1) begin
        foreach (field_set[i]) push(field_set[i][7:0], field_set[i][8], field_set[i][9]);
        drain();
      end
      rd_chk("avg_held", ADDR_AVG_LUMA, avg_exp);
      vfall();
      rd_chk("avg_field", ADDR_AVG_LUMA, avg_exp);
    end
    for (int m = 0; m < 8; m++) begin
      @(negedge clk_in);
      pll_disable_bit_in = m[0];
      oversample_enable_bit_in = m[1];
      reg_wr(ADDR_OCR, m[2] ? 8'h72 : 8'h70);
      repeat (2) @(negedge clk_in);
      check("aux_clk_en_out", {7'h00, m[2] & ~m[0] & m[1]}, {7'h00, aux_clk_en_out});
    end
    rd_chk("ocr_readback", ADDR_OCR, 8'h72);
    complete_run();
  end
endmodule
